/* File: dv/sncb_config_bank_assertions.sv */
//****************************************************************
// configuration bank checker
//****************************************************************
// Purpose: port properties of the configuration bank
// Assumes: one clock, asynchronous active-high reset
// Notes: helper flops mirror write data, latch bit and busy run
module sncb_config_bank_checker import sncb_pkg::*; #(
  parameter int WRITE_CYCLES = 4
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] acc_addr,
  input wire logic acc_wr,
  input wire logic [31:0] acc_wdata,
  input wire logic acc_rd,
  input wire logic [31:0] acc_rdata,
  input wire logic customer_access,
  input wire logic [2:0] rate_resolution_select,
  input wire logic [1:0] plate_mode,
  input wire logic crc_append,
  input wire logic input_level_1v8,
  input wire logic [2:0] axis_convert_en,
  input wire logic meas_valid,
  input wire logic int_status,
  input wire logic int_n,
  input wire logic record_write_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] wdata_reg;
  logic latch_reg;
  logic latch_next;
  logic [15:0] busy_cnt_reg;
  logic [15:0] busy_cnt_next;
  logic sense_wr;
  logic w1c;

  // qualified sensing word writes and status clears
  assign sense_wr = acc_wr && customer_access && acc_addr == OFS_SENSE;
  assign w1c = acc_wr && acc_addr == OFS_RESULT && acc_wdata[INT_STATUS_BIT];

  // latch bit mirror and length of the running record write
  always_comb begin
    latch_next = sense_wr ? acc_wdata[LATCH_BIT] : latch_reg;
    busy_cnt_next = record_write_busy ? busy_cnt_reg + 16'h0001 : 16'h0000;
  end

  // helper registers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wdata_reg <= 32'h0000_0000;
      latch_reg <= 1'b0;
      busy_cnt_reg <= 16'h0000;
    end else begin
      wdata_reg <= acc_wdata;
      latch_reg <= latch_next;
      busy_cnt_reg <= busy_cnt_next;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_sense_wr;
    sense_wr;
  endsequence

  sequence s_run_end;
    $fell(record_write_busy);
  endsequence

  chk_pin_inverse:
    assert property (int_n == !int_status) else $error("pin not inverse of status");
  chk_write_gated:
    assert property (acc_wr && !customer_access |=> $stable(rate_resolution_select)
      && $stable(axis_convert_en)) else $error("write taken without access");
  chk_cfg_outputs:
    assert property (s_sense_wr |=> rate_resolution_select == wdata_reg[23:21]
      && crc_append == wdata_reg[CRC_BIT] && input_level_1v8 == wdata_reg[LEVEL_BIT]
      && axis_convert_en == wdata_reg[8:6]) else $error("outputs differ from write");
  chk_plate_reserved:
    assert property (s_sense_wr ##0 acc_wdata[PLATE_LSB] |=> $stable(plate_mode))
      else $error("reserved plate code taken");
  chk_plate_taken:
    assert property (s_sense_wr ##0 !acc_wdata[PLATE_LSB] |=> plate_mode == wdata_reg[20:19])
      else $error("plate code not taken");
  chk_reserved_zero:
    assert property (acc_rd && acc_addr == OFS_SENSE |=> acc_rdata[31:24] == 8'h00)
      else $error("reserved bits read nonzero");
  chk_latch_hold:
    assert property (latch_reg && int_status && !w1c |=> int_status)
      else $error("latched status dropped");
  chk_record_len:
    assert property (s_run_end |-> busy_cnt_reg == 16'(WRITE_CYCLES))
      else $error("record write length wrong");
  chk_int_source:
    assert property ($rose(int_status) |-> $past(meas_valid, 2))
      else $error("status rose without a sample");
endmodule // sncb_config_bank_checker

bind sncb_config_bank sncb_config_bank_checker #(.WRITE_CYCLES(WRITE_CYCLES)) u_checker (
  .clk_sys(clk_sys), .reset(reset), .acc_addr(acc_addr), .acc_wr(acc_wr),
  .acc_wdata(acc_wdata), .acc_rd(acc_rd), .acc_rdata(acc_rdata),
  .customer_access(customer_access), .rate_resolution_select(rate_resolution_select),
  .plate_mode(plate_mode), .crc_append(crc_append), .input_level_1v8(input_level_1v8),
  .axis_convert_en(axis_convert_en), .meas_valid(meas_valid), .int_status(int_status),
  .int_n(int_n), .record_write_busy(record_write_busy)
);

/* File: dv/sncb_config_bank_test.sv */
//****************************************************************
// configuration bank testbench
//****************************************************************
// Purpose: drives words and samples, compares with a bench model
// Assumes: record write shortened to four cycles
// Notes: random words from a fixed seed
module sncb_config_bank_test import sncb_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WCYC = 4;
  logic clk_sys, reset, acc_wr, acc_rd, customer_access, addr_pins_at_supply, meas_valid;
  logic duty_cycled_low_power_mode, crc_append, input_level_1v8, int_status, int_n;
  logic record_write_busy;
  logic [ADDR_W-1:0] acc_addr;
  logic [31:0] acc_wdata, acc_rdata, rdata;
  logic [6:0] pin_address, bus_address;
  logic [11:0] meas_x, meas_y, meas_z;
  logic [2:0] rate_resolution_select, axis_convert_en;
  logic [1:0] plate_mode;
  int errors, check_count, cycles, exp_sense, exp_intc, exp_int, last_hit, ref_ok;
  int ref_v[3];

  sncb_config_bank #(.WRITE_CYCLES(WCYC)) dut (
    .clk_sys(clk_sys), .reset(reset), .acc_addr(acc_addr), .acc_wr(acc_wr),
    .acc_wdata(acc_wdata), .acc_rd(acc_rd), .acc_rdata(acc_rdata),
    .customer_access(customer_access), .addr_pins_at_supply(addr_pins_at_supply),
    .pin_address(pin_address), .bus_address(bus_address), .crc_append(crc_append),
    .input_level_1v8(input_level_1v8), .rate_resolution_select(rate_resolution_select),
    .plate_mode(plate_mode), .axis_convert_en(axis_convert_en), .meas_valid(meas_valid),
    .meas_x(meas_x), .meas_y(meas_y), .meas_z(meas_z),
    .duty_cycled_low_power_mode(duty_cycled_low_power_mode), .int_status(int_status),
    .int_n(int_n), .record_write_busy(record_write_busy)
  );

  sncb_host_model host (
    .clk_sys(clk_sys), .acc_addr(acc_addr), .acc_wr(acc_wr), .acc_wdata(acc_wdata),
    .acc_rd(acc_rd), .acc_rdata(acc_rdata)
  );

  // 20 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      print_verdict;
    end
  end

  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    host.get(a, rdata);
    check("read word", rdata, e);
  endtask

  // write through the host and update the model words
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    host.put(a, d);
    if (customer_access && a == OFS_SENSE) begin
      if (d[PLATE_LSB]) d[20:19] = exp_sense[20:19];
      exp_sense = d & SENSE_MASK;
    end
    if (customer_access && a == OFS_INTC) exp_intc = d & INTC_MASK;
    if (a == OFS_RESULT && d[INT_STATUS_BIT] && exp_sense[LATCH_BIT]) exp_int = last_hit;
  endtask

  task automatic chk_cfg;
    check("config outputs", {crc_append, input_level_1v8, rate_resolution_select, plate_mode,
      axis_convert_en}, {exp_sense[CRC_BIT], exp_sense[LEVEL_BIT], exp_sense[23:21],
      exp_sense[20:19], exp_sense[8:6]});
  endtask

  task automatic chk_int;
    check("interrupt", {int_status, int_n}, {exp_int[0], !exp_int[0]});
  endtask

  function automatic bit over(int v, int t);
    int s;
    s = (t > 31) ? t - 64 : t;
    if (exp_intc[SIGNED_BIT]) return (s < 0) ? v < s : v > s;
    return ((v < 0) ? -v : v) > t;
  endfunction

  // one sample on all axes, interrupt checked two cycles on
  task automatic sample(input int x, input int y, input int z);
    int v[3];
    int h;
    bit dl;
    v = '{x, y, z};
    h = 0;
    @(posedge clk_sys);
    meas_x <= x[11:0];
    meas_y <= y[11:0];
    meas_z <= z[11:0];
    meas_valid <= 1'b1;
    dl = exp_intc[DELTA_BIT] && duty_cycled_low_power_mode;
    if (dl && ref_ok == 0) begin
      ref_v = v;
      ref_ok = 1;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (exp_intc[INT_EN_LSB + i] && over(v[i] - (dl ? ref_v[i] : 0),
          exp_intc[THR_W * i +: THR_W])) h = 1;
      end
    end
    if (h && !last_hit && exp_intc[RECORD_EN_BIT]) exp_intc[RECORD_BIT] = 1;
    exp_int = exp_sense[LATCH_BIT] ? (exp_int | h) : h;
    last_hit = h;
    @(posedge clk_sys);
    meas_valid <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk_int;
  endtask

  // main sequence
  initial begin
    errors = 0;
    check_count = 0;
    cycles = 0;
    exp_int = 0;
    last_hit = 0;
    ref_ok = 0;
    exp_sense = SENSE_RESET;
    exp_intc = INTC_RESET;
    rdata = $urandom(8);
    reset = 1'b1;
    customer_access = 1'b0;
    addr_pins_at_supply = 1'b0;
    pin_address = 7'h00;
    meas_valid = 1'b0;
    meas_x = 12'h000;
    meas_y = 12'h000;
    meas_z = 12'h000;
    duty_cycled_low_power_mode = 1'b0;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    rd_chk(OFS_SENSE, exp_sense);
    rd_chk(OFS_INTC, exp_intc);
    chk_cfg;
    chk_int;
    wr(OFS_SENSE, 32'hFFFF_FFFF);
    rd_chk(OFS_SENSE, exp_sense);
    customer_access <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      wr(OFS_SENSE, $urandom());
      rd_chk(OFS_SENSE, exp_sense);
      chk_cfg;
      wr(OFS_INTC, $urandom());
      rd_chk(OFS_INTC, exp_intc);
    end
    for (int p = 0; p < 4; p++) begin
      wr(OFS_SENSE, 32'(p) << PLATE_LSB);
      @(negedge clk_sys);
      chk_cfg;
    end
    rd_chk(8'h10, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      pin_address <= 7'($urandom());
      addr_pins_at_supply <= i[0];
      wr(OFS_SENSE, 32'h0000_57C0 | (32'(i[1]) << PIN_DIS_BIT));
      repeat (6) @(posedge clk_sys);
      check("bus address", bus_address, (i > 0) ? 7'h15 : pin_address);
    end
    wr(OFS_SENSE, SENSE_RESET);
    wr(OFS_INTC, 32'h0004_0005);
    sample(6, 0, 0);
    sample(-5, 40, 40);
    sample(-6, 0, 0);
    wr(OFS_INTC, 32'h0104_0003);
    sample(-9, 0, 0);
    sample(4, 0, 0);
    wr(OFS_INTC, 32'h0104_003D);
    sample(-4, 0, 0);
    sample(10, 0, 0);
    wr(OFS_SENSE, SENSE_RESET | 32'h0000_0020);
    sample(-4, 0, 0);
    sample(0, 0, 0);
    rd_chk(OFS_RESULT, 32'h0000_0040);
    wr(OFS_RESULT, 32'h0000_0040);
    @(posedge clk_sys);
    chk_int;
    wr(OFS_SENSE, SENSE_RESET);
    wr(OFS_INTC, 32'h0024_0005);
    sample(9, 0, 0);
    host.get(OFS_STATUS, rdata);
    check("write busy", rdata[INT_WRITE_BIT], 1'b1);
    check("busy pin", record_write_busy, 1'b1);
    repeat (6) @(posedge clk_sys);
    rd_chk(OFS_INTC, exp_intc);
    wr(OFS_INTC, 32'h0084_0005);
    duty_cycled_low_power_mode <= 1'b1;
    sample(20, 0, 0);
    sample(24, 0, 0);
    sample(30, 0, 0);
    print_verdict;
  end
endmodule // sncb_config_bank_test

/* File: dv/sncb_host_model.sv */
//****************************************************************
// configuring host model
//****************************************************************
// Purpose: word reads and writes as the serial host issues them
// Assumes: one-cycle strobes, read word one cycle after the strobe
// Notes: released lines show the inverse of the last value
module sncb_host_model import sncb_pkg::*; (
  input wire logic clk_sys,
  output logic [ADDR_W-1:0] acc_addr,
  output logic acc_wr,
  output logic [31:0] acc_wdata,
  output logic acc_rd,
  input wire logic [31:0] acc_rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle bus at time zero
  initial begin
    acc_addr = 8'h00;
    acc_wr = 1'b0;
    acc_wdata = 32'h0000_0000;
    acc_rd = 1'b0;
  end

  // one write strobe, then the lines are let go
  task automatic put(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    acc_addr <= a;
    acc_wdata <= d;
    acc_wr <= 1'b1;
    @(posedge clk_sys);
    acc_wr <= 1'b0;
    acc_addr <= ~a;
    acc_wdata <= ~d;
  endtask

  // one read strobe, word taken once it has landed
  task automatic get(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    acc_addr <= a;
    acc_rd <= 1'b1;
    @(posedge clk_sys);
    acc_rd <= 1'b0;
    acc_addr <= ~a;
    @(posedge clk_sys);
    d = acc_rdata;
  endtask
endmodule // sncb_host_model

/* File: rtl/sncb_axis_compare.sv */
//****************************************************************
// per-axis threshold comparator
//****************************************************************
// Purpose: turns samples and interrupt word into an event level
// Assumes: samples are 12-bit two's complement
// Notes: threshold scaled by THR_SHIFT onto the sample range
module sncb_axis_compare import sncb_pkg::*; #(
  parameter int THR_SHIFT = 0
) (
  input wire logic clk_sys,
  input wire logic reset,
  sncb_cmp_if.compare cmp
);

  typedef struct packed {
    logic [11:0] ref_x;
    logic [11:0] ref_y;
    logic [11:0] ref_z;
    logic have_ref;
    logic hit;
  } sncb_cmp_st_t;

  sncb_cmp_st_t st_reg;
  sncb_cmp_st_t st_next;

  // one axis against its threshold, signed or absolute
  function automatic logic axis_hit(input logic signed [12:0] v, input logic [5:0] thr,
                                    input logic signed_mode);
    logic signed [12:0] ts;
    logic [12:0] tu;
    logic [12:0] mag;
    ts = $signed({{7{thr[5]}}, thr}) <<< THR_SHIFT;
    tu = {7'h00, thr} << THR_SHIFT;
    mag = v[12] ? 13'(-v) : 13'(v);
    if (signed_mode) begin
      return ts[12] ? (v < ts) : (v > ts);
    end
    return mag > tu;
  endfunction

  // signed difference or plain sample widened to 13 bits
  function automatic logic signed [12:0] axis_val(input logic [11:0] m, input logic [11:0] r,
                                                  input logic use_ref);
    logic signed [12:0] mv;
    mv = $signed({m[11], m});
    return use_ref ? 13'(mv - $signed({r[11], r})) : mv;
  endfunction

  // next state
  always_comb begin
    logic delta;
    logic sgn;
    logic [2:0] en;
    delta = cmp.int_cfg[DELTA_BIT] && cmp.lp_active;
    sgn = cmp.int_cfg[SIGNED_BIT];
    en = cmp.int_cfg[INT_EN_LSB +: 3];
    st_next = st_reg;
    if (!cmp.lp_active) begin
      st_next.have_ref = 1'b0;
    end
    if (cmp.meas_valid) begin
      if (delta && !st_reg.have_ref) begin
        st_next.ref_x = cmp.meas_x;
        st_next.ref_y = cmp.meas_y;
        st_next.ref_z = cmp.meas_z;
        st_next.have_ref = 1'b1;
        st_next.hit = 1'b0;
      end else begin
        st_next.hit =
          (en[0] && axis_hit(axis_val(cmp.meas_x, st_reg.ref_x, delta),
                             cmp.int_cfg[THR_X_LSB +: THR_W], sgn)) ||
          (en[1] && axis_hit(axis_val(cmp.meas_y, st_reg.ref_y, delta),
                             cmp.int_cfg[THR_Y_LSB +: THR_W], sgn)) ||
          (en[2] && axis_hit(axis_val(cmp.meas_z, st_reg.ref_z, delta),
                             cmp.int_cfg[THR_Z_LSB +: THR_W], sgn));
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cmp.hit = st_reg.hit;

endmodule // sncb_axis_compare

/* File: rtl/sncb_config_bank.sv */
//****************************************************************
// sensor non-volatile configuration bank
//****************************************************************
// Purpose: two configuration words, interrupt status and bus address
// Assumes: serial front end presents decoded word reads and writes
// Notes: words reset to their defaults, standing in for stored values
module sncb_config_bank import sncb_pkg::*; #(
  parameter logic [1:0] PLATE_DEFAULT = PLATE_SINGLE,
  parameter int THR_SHIFT = 0,
  parameter int WRITE_CYCLES = NV_WRITE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] acc_addr,
  input wire logic acc_wr,
  input wire logic [31:0] acc_wdata,
  input wire logic acc_rd,
  output logic [31:0] acc_rdata,
  input wire logic customer_access,
  input wire logic addr_pins_at_supply,
  input wire logic [6:0] pin_address,
  output logic [6:0] bus_address,
  output logic crc_append,
  output logic input_level_1v8,
  output logic [2:0] rate_resolution_select,
  output logic [1:0] plate_mode,
  output logic [2:0] axis_convert_en,
  input wire logic meas_valid,
  input wire logic [11:0] meas_x,
  input wire logic [11:0] meas_y,
  input wire logic [11:0] meas_z,
  input wire logic duty_cycled_low_power_mode,
  output logic int_status,
  output logic int_n,
  output logic record_write_busy
);

  //****************************************************************
  // state
  //****************************************************************
  typedef struct packed {
    logic [31:0] sense;
    logic [31:0] intc;
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    logic pin_high;
    logic [6:0] addr;
    logic int_status;
    logic hit_q;
    logic nvw_start;
    logic [31:0] rdata;
  } sncb_bank_st_t;

  sncb_bank_st_t st_reg;
  sncb_bank_st_t st_next;

  sncb_cmp_if cmp_if ();
  sncb_nvw_if nvw_if ();

  //****************************************************************
  // helpers
  //****************************************************************

  // plate mode code allowed to be stored
  function automatic logic plate_ok(input logic [1:0] code);
    return (code == PLATE_SINGLE) || (code == PLATE_COMMON);
  endfunction

  // word presented on a read of the given offset
  function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a,
                                            input sncb_bank_st_t s, input logic busy);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      OFS_SENSE: w = s.sense & SENSE_MASK;
      OFS_INTC: w = s.intc & INTC_MASK;
      OFS_RESULT: w[INT_STATUS_BIT] = s.int_status;
      OFS_STATUS: w[INT_WRITE_BIT] = busy;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  //****************************************************************
  // helper instances
  //****************************************************************

  // samples and interrupt word to comparator
  assign cmp_if.int_cfg = st_reg.intc;
  assign cmp_if.meas_valid = meas_valid;
  assign cmp_if.meas_x = meas_x;
  assign cmp_if.meas_y = meas_y;
  assign cmp_if.meas_z = meas_z;
  assign cmp_if.lp_active = duty_cycled_low_power_mode;
  assign nvw_if.start = st_reg.nvw_start;

  sncb_axis_compare #(
    .THR_SHIFT(THR_SHIFT)
  ) u_compare (
    .clk_sys(clk_sys),
    .reset(reset),
    .cmp(cmp_if.compare)
  );

  sncb_record_writer #(
    .WRITE_CYCLES(WRITE_CYCLES)
  ) u_writer (
    .clk_sys(clk_sys),
    .reset(reset),
    .nvw(nvw_if.writer)
  );

  //****************************************************************
  // next state
  //****************************************************************
  always_comb begin
    logic wr_sense;
    logic wr_intc;
    logic wr_result;
    logic [31:0] w;
    logic event_rise;
    wr_sense = 1'b0;
    wr_intc = 1'b0;
    wr_result = 1'b0;
    w = 32'h0000_0000;
    event_rise = 1'b0;
    st_next = st_reg;

    // three-stage pin synchroniser, change taken when stages two and three agree
    st_next.pin_s1 = addr_pins_at_supply;
    st_next.pin_s2 = st_reg.pin_s1;
    st_next.pin_s3 = st_reg.pin_s2;
    if (st_reg.pin_s2 == st_reg.pin_s3) begin
      st_next.pin_high = st_reg.pin_s3;
    end

    if (acc_wr && customer_access) begin
      wr_sense = (acc_addr == OFS_SENSE);
      wr_intc = (acc_addr == OFS_INTC);
    end
    // volatile result word clear is not access gated
    wr_result = acc_wr && (acc_addr == OFS_RESULT);

    // sensing and bus word update
    if (wr_sense) begin
      w = acc_wdata & SENSE_MASK;
      // reserved plate codes keep the old mode
      if (!plate_ok(w[PLATE_LSB +: 2])) begin
        w[PLATE_LSB +: 2] = st_reg.sense[PLATE_LSB +: 2];
      end
      // user bits stored, read nowhere else
      st_next.sense = w;
    end

    if (wr_intc) begin
      st_next.intc = acc_wdata & INTC_MASK;
    end

    // record programmed on each new event while bit 21 is set and the writer is idle
    event_rise = cmp_if.hit && !st_reg.hit_q;
    st_next.hit_q = cmp_if.hit;
    st_next.nvw_start = event_rise && st_reg.intc[RECORD_EN_BIT] && !nvw_if.busy;
    // completed programming sets record, wins over a write
    if (nvw_if.done) begin
      st_next.intc[RECORD_BIT] = 1'b1;
    end

    // latched status holds, plain status follows the event
    if (st_reg.sense[LATCH_BIT]) begin
      // write one clears, a new event wins
      if (wr_result && acc_wdata[INT_STATUS_BIT]) begin
        st_next.int_status = 1'b0;
      end
      if (cmp_if.hit) begin
        st_next.int_status = 1'b1;
      end
    end else begin
      st_next.int_status = cmp_if.hit;
    end

    if (st_reg.sense[PIN_DIS_BIT] || st_reg.pin_high) begin
      st_next.addr = st_reg.sense[ADDR_LSB +: 7];
    end else begin
      st_next.addr = pin_address;
    end

    if (acc_rd) begin
      st_next.rdata = read_word(acc_addr, st_reg, nvw_if.busy);
    end
  end

  //****************************************************************
  // state register
  //****************************************************************
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_reg <= '{sense: SENSE_RESET | (32'(PLATE_DEFAULT) << PLATE_LSB),
                  intc: INTC_RESET,
                  default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  //****************************************************************
  // outputs
  //****************************************************************

  // read data and address from flops
  assign acc_rdata = st_reg.rdata;
  assign bus_address = st_reg.addr;

  // checksum byte request to the serial front end
  assign crc_append = st_reg.sense[CRC_BIT];

  assign input_level_1v8 = st_reg.sense[LEVEL_BIT];

  assign rate_resolution_select = st_reg.sense[RATE_LSB +: 3];

  assign plate_mode = st_reg.sense[PLATE_LSB +: 2];

  // conversion enables, bit 0 X, bit 1 Y, bit 2 Z
  assign axis_convert_en = st_reg.sense[AXIS_EN_LSB +: 3];

  // status and active-low output track together
  assign int_status = st_reg.int_status;
  assign int_n = !st_reg.int_status;

  assign record_write_busy = nvw_if.busy;

endmodule // sncb_config_bank

/* File: rtl/sncb_if.sv */
//****************************************************************
// carriers between the bank and its helpers
//****************************************************************
// Purpose: comparator and record-writer connections
// Assumes: single clock domain
// Notes: none

// comparator: configuration and samples in, hit out
interface sncb_cmp_if;
  logic [31:0] int_cfg;
  logic meas_valid;
  logic [11:0] meas_x;
  logic [11:0] meas_y;
  logic [11:0] meas_z;
  logic lp_active;
  logic hit;
  modport bank (output int_cfg, meas_valid, meas_x, meas_y, meas_z, lp_active, input hit);
  modport compare (input int_cfg, meas_valid, meas_x, meas_y, meas_z, lp_active, output hit);
endinterface : sncb_cmp_if

// record writer: start pulse in, busy level and done pulse out
interface sncb_nvw_if;
  logic start;
  logic busy;
  logic done;
  modport bank (output start, input busy, done);
  modport writer (input start, output busy, done);
endinterface : sncb_nvw_if

/* File: rtl/sncb_pkg.sv */
//****************************************************************
// sensor non-volatile configuration bank constants
//****************************************************************
// Purpose: offsets, field positions, reset values and timing of the bank
// Assumes: word access port delivered by the serial front end
// Notes: one word per offset, reserved bits read as zero
// Behaviour
// - reads always allowed, writes need customer access except the result word clear
// - bits 23:21 select rate versus resolution
// - plate mode 0 single, 2 common, others refused
// - checksum enable appends check byte to reads
// - bit 17 set ignores address select pins
// - stored address used when disabled or pins high
// - bit 9 selects 1.8 V or 3 V levels
// - bits 8:6 enable Z, Y, X conversions
// - bit 5 latches interrupt status and output
// - bits 4:0 are inert user storage bits
// - bit 24 selects signed or absolute compare
// - bit 23 selects threshold or delta compare, delta only in duty-cycled low power mode
// - bit 22 is the stored event record
// - bit 21 auto-programs the event record
// - bits 20:18 enable Z, Y, X interrupts
// - six-bit thresholds Z 17:12, Y 11:6, X 5:0
// - latched status cleared by writing one only
package sncb_pkg;

  //****************************************************************
  // word offsets
  //****************************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_SENSE = 8'h02;
  localparam logic [7:0] OFS_INTC = 8'h03;
  localparam logic [7:0] OFS_RESULT = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h29;

  //****************************************************************
  // sensing and bus word fields
  //****************************************************************
  localparam int RATE_LSB = 21;
  localparam int PLATE_LSB = 19;
  localparam int CRC_BIT = 18;
  localparam int PIN_DIS_BIT = 17;
  localparam int ADDR_LSB = 10;
  localparam int LEVEL_BIT = 9;
  localparam int AXIS_EN_LSB = 6;
  localparam int LATCH_BIT = 5;
  localparam logic [31:0] SENSE_MASK = 32'h00FF_FFFF;
  localparam logic [31:0] SENSE_RESET = 32'h0000_03C0;
  localparam logic [1:0] PLATE_SINGLE = 2'h0;
  localparam logic [1:0] PLATE_COMMON = 2'h2;

  //****************************************************************
  // interrupt word fields
  //****************************************************************
  localparam int SIGNED_BIT = 24;
  localparam int DELTA_BIT = 23;
  localparam int RECORD_BIT = 22;
  localparam int RECORD_EN_BIT = 21;
  localparam int INT_EN_LSB = 18;
  localparam int THR_W = 6;
  localparam int THR_X_LSB = 0;
  localparam int THR_Y_LSB = 6;
  localparam int THR_Z_LSB = 12;
  localparam logic [31:0] INTC_MASK = 32'h01FF_FFFF;
  localparam logic [31:0] INTC_RESET = 32'h0000_0000;

  //****************************************************************
  // volatile word bits
  //****************************************************************
  localparam int INT_STATUS_BIT = 6;
  localparam int INT_WRITE_BIT = 20;

  //****************************************************************
  // timing
  //****************************************************************
  localparam int CLK_HZ = 20_000_000;
  localparam int NV_WRITE_TIME_US = 10;
  localparam int NV_WRITE_CYCLES = NV_WRITE_TIME_US * (CLK_HZ / 1_000_000);

endpackage : sncb_pkg

/* File: rtl/sncb_record_writer.sv */
//****************************************************************
// non-volatile record write timer
//****************************************************************
// Purpose: models the programming time of the event record bit
// Assumes: start ignored while busy
// Notes: done pulses one cycle as busy falls
module sncb_record_writer import sncb_pkg::*; #(
  parameter int WRITE_CYCLES = NV_WRITE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  sncb_nvw_if.writer nvw
);

  typedef struct packed {
    logic busy;
    logic done;
    logic [15:0] count;
  } sncb_nvw_st_t;

  sncb_nvw_st_t st_reg;
  sncb_nvw_st_t st_next;

  // programming countdown
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (!st_reg.busy) begin
      if (nvw.start) begin
        st_next.busy = 1'b1;
        st_next.count = 16'(WRITE_CYCLES - 1);
      end
    end else if (st_reg.count == 16'h0000) begin
      st_next.busy = 1'b0;
      st_next.done = 1'b1;
    end else begin
      st_next.count = st_reg.count - 16'h0001;
    end
  end

  // state register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign nvw.busy = st_reg.busy;
  assign nvw.done = st_reg.done;

endmodule // sncb_record_writer
